// >>> core/ext_bus_ctrl.sv
/*
  external bus controller: runs on-chip requests as external cycles.
  assumes a request is held until ack; configuration ports static
  while an access runs; pins resolved outside from the enables.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ext_bus_consts.svh"
module ext_bus_ctrl
  import ext_bus_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  // on-chip request
  input wire logic req_in,
  input wire logic req_wr_in,
  input wire logic [23:0] req_addr_in,
  input wire logic [15:0] req_wdata_in,
  output logic ack_out,
  output logic [15:0] rdata_out,
  // configuration
  input wire bus_mode_t bus_mode_in,
  input wire addr_width_t addr_width_in,
  input wire can_assign_t can_assign_in,
  input wire logic [63:0] window_select_reg_in,
  input wire logic [7:0] default_bus_config_in,
  input wire logic [31:0] window_bus_config_in,
  input wire logic unlatched_select_bit_in,
  input wire logic arbitration_enable_in,
  input wire logic hold_ack_direction_bit_in,
  // address and data pins
  output logic [15:0] address_port_out,
  output logic address_port_oe_out,
  input wire logic [15:0] addr_data_port_in,
  output logic [15:0] addr_data_port_out,
  output logic [15:0] addr_data_port_oe_out,
  output logic [7:0] segment_out,
  output logic [7:0] segment_oe_out,
  // strobes and selects
  output logic ale_out,
  output logic rd_b_out,
  output logic wr_b_out,
  output logic ctrl_oe_out,
  output logic [4:0] cs_b_out,
  input wire logic ready_b_in,
  // arbitration
  input wire logic hold_b_in,
  input wire logic hold_ack_b_in,
  output logic hold_ack_b_out,
  output logic hold_ack_oe_out,
  output logic bus_request_b_out
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_DLY,
    ST_DATA,
    ST_TRI,
    ST_HOLD
  } state_t;

  // ==========================================
  // window decode and segment lines
  logic [2:0] win_idx;
  logic [4:0] cs_hit;
  logic [7:0] seg_oe;
  logic [7:0] cfg;

  window_decode u_win (
    .addr_in(req_addr_in),
    .win_sel_in(window_select_reg_in),
    .win_idx_out(win_idx),
    .cs_hit_out(cs_hit)
  );

  segment_port u_seg (
    .aw_in(addr_width_in),
    .can_in(can_assign_in),
    .seg_oe_out(seg_oe)
  );

  // [RULE6] config of the hit window
  // [RULE8] default config when no window hits
  always_comb begin
    if (win_idx == 3'h0) begin
      cfg = default_bus_config_in;
    end else begin
      cfg = window_bus_config_in[(win_idx - 3'h1)*8 +: 8];
    end
  end

  function automatic logic is_mux(input bus_mode_t m);
    is_mux = (m == MODE_D16_MUX) || (m == MODE_D8_MUX);
  endfunction

  function automatic logic is_d8(input bus_mode_t m);
    is_d8 = (m == MODE_D8_MUX) || (m == MODE_D8_DEMUX);
  endfunction

  // [RULE2] address cut to the chosen width
  function automatic logic [23:0] cut_addr(input logic [23:0] a,
                                           input addr_width_t w);
    case (w)
      AW_16: cut_addr = {8'h00, a[15:0]};
      AW_18: cut_addr = {6'h00, a[17:0]};
      AW_20: cut_addr = {4'h0, a[19:0]};
      default: cut_addr = a;
    endcase
  endfunction

  // ==========================================
  // arbitration view
  logic slave;
  logic granted;
  assign slave = hold_ack_direction_bit_in;
  // [RULE14] slave owns bus only while acknowledge input is low
  assign granted = !slave || !hold_ack_b_in;

  // ==========================================
  // access state
  state_t state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] cfg_r, cfg_nxt;
  logic wr_r, wr_nxt;
  logic [23:0] addr_r, addr_nxt;
  logic [15:0] wdata_r, wdata_nxt;
  logic [4:0] csl_r, csl_nxt;
  logic ack_r, ack_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic go;
  logic held;
  logic rdy_ok;

  assign go = req_in && !ack_r && (bus_mode_in != MODE_SINGLE);
  // [RULE11] ready extends the data phase
  assign rdy_ok = !cfg_r[`CFG_RDY_EN] || !ready_b_in;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    cfg_nxt = cfg_r;
    wr_nxt = wr_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    csl_nxt = csl_r;
    ack_nxt = 1'b0;
    rdata_nxt = rdata_r;
    // [RULE12] hold handled only with arbitration enabled
    held = arbitration_enable_in && (slave ? !granted : !hold_b_in);
    case (state_r)
      ST_IDLE: begin
        // [RULE18] no new access while held
        if (held) begin
          state_nxt = ST_HOLD;
        end else if (go) begin
          // [RULE5] latch strobe length
          state_nxt = ST_ADDR;
          cnt_nxt = cfg[`CFG_ALE_LONG] ? `ALE_LONG_CYC : `ALE_SHORT_CYC;
          cfg_nxt = cfg;
          wr_nxt = req_wr_in;
          addr_nxt = cut_addr(req_addr_in, addr_width_in);
          wdata_nxt = req_wdata_in;
          csl_nxt = cs_hit;
        end
      end
      ST_ADDR: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h1) begin
          cnt_nxt = cfg_r[`CFG_WAIT_HI:`CFG_WAIT_LO];
          // [RULE5] read/write delay
          state_nxt = cfg_r[`CFG_RW_DLY] ? ST_DLY : ST_DATA;
        end
      end
      ST_DLY: begin
        state_nxt = ST_DATA;
      end
      ST_DATA: begin
        // [RULE5] memory cycle time
        if (cnt_r != 4'h0) begin
          cnt_nxt = cnt_r - 4'h1;
        end else if (rdy_ok) begin
          ack_nxt = 1'b1;
          if (is_d8(bus_mode_in)) begin
            rdata_nxt = {8'h00, addr_data_port_in[7:0]};
          end else begin
            rdata_nxt = addr_data_port_in;
          end
          // [RULE5] memory tri-state time
          if (cfg_r[`CFG_TRI]) begin
            state_nxt = ST_TRI;
            cnt_nxt = `TRI_CYC;
          end else begin
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_TRI: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h1) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_HOLD: begin
        // [RULE18] resume on release
        if (!held) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      cfg_r <= `CFG_RESET;
      wr_r <= 1'b0;
      addr_r <= 24'h000000;
      wdata_r <= 16'h0000;
      csl_r <= 5'h00;
      ack_r <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      cfg_r <= cfg_nxt;
      wr_r <= wr_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      csl_r <= csl_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================
  // pin drive, registered
  logic [15:0] apo_r, apo_nxt;
  logic apoe_r, apoe_nxt;
  logic [15:0] ado_r, ado_nxt;
  logic [15:0] adoe_r, adoe_nxt;
  logic [7:0] seg_r, seg_nxt;
  logic [7:0] segoe_r, segoe_nxt;
  logic ale_r, ale_nxt;
  logic rd_b_r, rd_b_nxt;
  logic wr_b_r, wr_b_nxt;
  logic ctoe_r, ctoe_nxt;
  logic [4:0] cs_b_r, cs_b_nxt;
  logic hab_r, hab_nxt;
  logic haoe_r, haoe_nxt;
  logic bus_request_out_b_r, bus_request_out_b_nxt;
  logic busy;
  logic strobe;
  logic [15:0] dmask;

  assign busy = (state_nxt != ST_IDLE) && (state_nxt != ST_HOLD);
  assign strobe = (state_nxt == ST_DATA);
  assign dmask = is_d8(bus_mode_in) ? 16'h00ff : 16'hffff;

  always_comb begin
    // [RULE1] single-chip leaves all bus pins undriven
    // [RULE18] held: everything released
    apoe_nxt = busy && !is_mux(bus_mode_in);
    apo_nxt = addr_nxt[15:0];
    ado_nxt = 16'h0000;
    adoe_nxt = 16'h0000;
    if (busy && is_mux(bus_mode_in) && (state_nxt == ST_ADDR)) begin
      // [RULE4] address phase on addr/data port
      ado_nxt = addr_nxt[15:0];
      adoe_nxt = 16'hffff;
    end else if (strobe && wr_nxt) begin
      // [RULE3] data on port or its low byte
      ado_nxt = wdata_nxt & dmask;
      adoe_nxt = dmask;
    end
    seg_nxt = addr_nxt[23:16];
    segoe_nxt = busy ? seg_oe : 8'h00;
    ale_nxt = (state_nxt == ST_ADDR);
    rd_b_nxt = !(strobe && !wr_nxt);
    wr_b_nxt = !(strobe && wr_nxt);
    ctoe_nxt = (bus_mode_in != MODE_SINGLE) && (state_nxt != ST_HOLD);
    // [RULE10] unlatched: straight from address
    if (unlatched_select_bit_in) begin
      cs_b_nxt = busy ? ~cs_hit : 5'h1f;
    end else begin
      cs_b_nxt = busy ? ~csl_nxt : 5'h1f;
    end
    // [RULE13] master drives acknowledge
    haoe_nxt = arbitration_enable_in ? !slave : 1'b1;
    hab_nxt = !(state_nxt == ST_HOLD && !slave);
    // [RULE12] request bus while held with work pending
    bus_request_out_b_nxt = !(arbitration_enable_in && held && req_in);
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      apo_r <= 16'h0000;
      apoe_r <= 1'b0;
      ado_r <= 16'h0000;
      adoe_r <= 16'h0000;
      seg_r <= 8'h00;
      segoe_r <= 8'h00;
      ale_r <= 1'b0;
      rd_b_r <= 1'b1;
      wr_b_r <= 1'b1;
      ctoe_r <= 1'b0;
      cs_b_r <= 5'h1f;
      hab_r <= 1'b1;
      haoe_r <= 1'b1;
      bus_request_out_b_r <= 1'b1;
    end else begin
      apo_r <= apo_nxt;
      apoe_r <= apoe_nxt;
      ado_r <= ado_nxt;
      adoe_r <= adoe_nxt;
      seg_r <= seg_nxt;
      segoe_r <= segoe_nxt;
      ale_r <= ale_nxt;
      rd_b_r <= rd_b_nxt;
      wr_b_r <= wr_b_nxt;
      ctoe_r <= ctoe_nxt;
      cs_b_r <= cs_b_nxt;
      hab_r <= hab_nxt;
      haoe_r <= haoe_nxt;
      bus_request_out_b_r <= bus_request_out_b_nxt;
    end
  end

  assign ack_out = ack_r;
  assign rdata_out = rdata_r;
  assign address_port_out = apo_r;
  assign address_port_oe_out = apoe_r;
  assign addr_data_port_out = ado_r;
  assign addr_data_port_oe_out = adoe_r;
  assign segment_out = seg_r;
  assign segment_oe_out = segoe_r;
  assign ale_out = ale_r;
  assign rd_b_out = rd_b_r;
  assign wr_b_out = wr_b_r;
  assign ctrl_oe_out = ctoe_r;
  assign cs_b_out = cs_b_r;
  assign hold_ack_b_out = hab_r;
  assign hold_ack_oe_out = haoe_r;
  assign bus_request_b_out = bus_request_out_b_r;
endmodule
`default_nettype wire

// >>> core/ext_bus_consts.svh
/*
  constants of the external bus controller: config field positions,
  reset values and timing counts.
  assumes inclusion by bare name from every design module file.
*/
// Functional notes
// [RULE1] single-chip mode plus 16/8-bit data, multiplexed or demultiplexed modes
// [RULE2] external address width selectable as 16, 18, 20 or 24 bits
// [RULE3] demux: address on address port, data on addr/data port or low byte
// [RULE4] mux: addr/data port carries address first, then data
// [RULE5] cycle time, tri-state time, latch strobe length, rw delay programmable
// [RULE6] four address windows, each a select register plus bus config
// [RULE7] window four beats three, window two beats one on overlap
// [RULE8] addresses outside all windows use the default bus config
// [RULE9] five chip selects: four windows plus default region
// [RULE10] unlatched select bit bypasses filter, selects decoded straight from address
// [RULE11] ready input extends accesses; slow devices signal readiness on it
// [RULE12] arbitration enable hands request, acknowledge, hold pins to controller
// [RULE13] after reset: arbitration master, hold acknowledge driven as output
// [RULE14] direction bit one selects slave; hold acknowledge becomes input
// [RULE15] 1M, 256K, 64K space give four, two, zero segment lines
// [RULE16] full space drives all eight segment lines
// [RULE17] CAN lines on segment port limit segment output to 6 or 4
// [RULE18] during hold: outputs high impedance, accesses suspended until release
`ifndef EXT_BUS_CONSTS_SVH
`define EXT_BUS_CONSTS_SVH

// ==========================================
// bus config fields
`define CFG_WAIT_LO 0
`define CFG_WAIT_HI 3
`define CFG_TRI 4
`define CFG_ALE_LONG 5
`define CFG_RW_DLY 6
`define CFG_RDY_EN 7
`define CFG_RESET 8'h0f

// ==========================================
// window select fields: base above, size code below
`define SEL_BASE_LO 4
`define SEL_BASE_HI 15
`define SEL_SIZE_HI 3

// ==========================================
// timing counts in cycles
`define ALE_SHORT_CYC 4'h1
`define ALE_LONG_CYC 4'h2
`define TRI_CYC 4'h1

`endif

// >>> core/ext_bus_pkg.sv
/*
  types of the external bus controller.
  assumes nothing beyond a SystemVerilog compiler.
*/
package ext_bus_pkg;
  typedef enum logic [2:0] {
    MODE_SINGLE,
    MODE_D16_DEMUX,
    MODE_D16_MUX,
    MODE_D8_MUX,
    MODE_D8_DEMUX
  } bus_mode_t;

  // also the segment address space
  typedef enum logic [1:0] {
    AW_16,
    AW_18,
    AW_20,
    AW_24
  } addr_width_t;

  typedef enum logic [1:0] {
    CAN_NONE,
    CAN_LIMIT6,
    CAN_LIMIT4
  } can_assign_t;
endpackage

// >>> core/window_decode.sv
/*
  address window decode: four windows and a default region.
  assumes select words packed window one lowest.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ext_bus_consts.svh"
module window_decode (
  // address and windows
  input wire logic [23:0] addr_in,
  input wire logic [63:0] win_sel_in,
  // result
  output logic [2:0] win_idx_out,
  output logic [4:0] cs_hit_out
);
  // base compared above the window size
  function automatic logic hit(input logic [23:0] a, input logic [15:0] s);
    logic [11:0] base;
    logic [11:0] msk;
    base = s[`SEL_BASE_HI:`SEL_BASE_LO];
    msk = 12'hfff << s[`SEL_SIZE_HI:0];
    hit = ((a[23:12] ^ base) & msk) == 12'h000;
  endfunction

  always_comb begin
    win_idx_out = 3'h0;
    // [RULE7] four over three over two over one
    for (int i = 0; i < 4; i++) begin
      if (hit(addr_in, win_sel_in[i*16 +: 16])) begin
        win_idx_out = 3'(i + 1);
      end
    end
    // [RULE9] one select per window plus default
    cs_hit_out = 5'h01 << win_idx_out;
  end
endmodule
`default_nettype wire

// >>> core/segment_port.sv
/*
  segment address port: upper address lines per space and CAN sharing.
  assumes address width and CAN assignment held stable by software.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ext_bus_consts.svh"
module segment_port
  import ext_bus_pkg::*;
(
  // configuration
  input wire addr_width_t aw_in,
  input wire can_assign_t can_in,
  // output lines
  output logic [7:0] seg_oe_out
);
  logic [7:0] aw_mask;
  logic [7:0] can_mask;

  always_comb begin
    // [RULE15] four, two or no lines
    // [RULE16] all eight for full space
    case (aw_in)
      AW_16: aw_mask = 8'h00;
      AW_18: aw_mask = 8'h03;
      AW_20: aw_mask = 8'h0f;
      AW_24: aw_mask = 8'hff;
      default: aw_mask = 8'h00;
    endcase
    // [RULE17] CAN lines take priority
    case (can_in)
      CAN_LIMIT6: can_mask = 8'h3f;
      CAN_LIMIT4: can_mask = 8'h0f;
      default: can_mask = 8'hff;
    endcase
    seg_oe_out = aw_mask & can_mask;
  end
endmodule
`default_nettype wire

// >>> tb/ext_bus_ctrl_asserts.sv
/*
  port checker of the external bus controller.
  assumes it is bound onto ext_bus_ctrl; one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module ext_bus_ctrl_asserts
  import ext_bus_pkg::*;
(
  // clock, reset, configuration
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire bus_mode_t bus_mode_in,
  input wire addr_width_t addr_width_in,
  input wire can_assign_t can_assign_in,
  input wire logic arbitration_enable_in,
  input wire logic hold_ack_direction_bit_in,
  // watched outputs
  input wire logic ack_out,
  input wire logic address_port_oe_out,
  input wire logic [15:0] addr_data_port_oe_out,
  input wire logic [7:0] segment_oe_out,
  input wire logic ale_out,
  input wire logic rd_b_out,
  input wire logic wr_b_out,
  input wire logic ctrl_oe_out,
  input wire logic [4:0] cs_b_out,
  input wire logic hold_ack_b_out,
  input wire logic hold_ack_oe_out
);
  // ==========================================
  // segment lines allowed
  logic [7:0] seg_max;
  always_comb begin
    case (addr_width_in)
      AW_16: seg_max = 8'h00;
      AW_18: seg_max = 8'h03;
      AW_20: seg_max = 8'h0f;
      default: seg_max = 8'hff;
    endcase
    if (can_assign_in == CAN_LIMIT6) begin
      seg_max = seg_max & 8'h3f;
    end
    if (can_assign_in == CAN_LIMIT4) begin
      seg_max = seg_max & 8'h0f;
    end
  end
  // ==========================================
  // properties
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  sequence addr_phase;
    $rose(ale_out);
  endsequence
  sequence data_phase;
    !ale_out && !(rd_b_out && wr_b_out);
  endsequence
  a_addr_then_data: assert property (addr_phase |-> ##[1:3] data_phase)
    else $error("no strobe after address phase");
  a_access_bound: assert property (addr_phase |-> ##[2:60] ack_out)
    else $error("access not closed in time");
  a_ack_pulse: assert property (ack_out |=> !ack_out)
    else $error("ack longer than one cycle");
  a_single_quiet: assert property ((bus_mode_in == MODE_SINGLE) [*3] |-> !ack_out && !ctrl_oe_out)
    else $error("bus activity in single-chip mode");
  a_mux_shared: assert property ((bus_mode_in inside {MODE_D16_MUX, MODE_D8_MUX}) [*2] |-> !address_port_oe_out)
    else $error("address port driven in multiplexed mode");
  a_one_select: assert property ($onehot0(~cs_b_out))
    else $error("more than one select active");
  a_hold_float: assert property (hold_ack_oe_out && !hold_ack_b_out |-> !ctrl_oe_out && !address_port_oe_out
    && addr_data_port_oe_out == 16'h0000 && segment_oe_out == 8'h00)
    else $error("bus driven during hold");
  a_seg_limit: assert property (($stable(addr_width_in) && $stable(can_assign_in)) [*2]
    |-> (segment_oe_out & ~seg_max) == 8'h00)
    else $error("too many segment lines driven");
  a_master_drive: assert property ((!hold_ack_direction_bit_in) [*2] |-> hold_ack_oe_out)
    else $error("acknowledge pin not driven as master");
  a_slave_input: assert property ((hold_ack_direction_bit_in && arbitration_enable_in) [*2] |-> !hold_ack_oe_out)
    else $error("acknowledge pin driven as slave");
endmodule
`default_nettype wire

// >>> tb/ext_mem_model.sv
/*
  external memory with a ready line, on the far side of the bus.
  assumes selects ignored; address taken while ale is high.
*/
`timescale 1ns/10ps
`default_nettype none
module ext_mem_model (
  // bus from the controller
  input wire logic clk_in,
  input wire logic [15:0] address_port_in,
  input wire logic address_port_oe_in,
  input wire logic [15:0] ad_out_in,
  input wire logic [15:0] ad_oe_in,
  input wire logic ale_in,
  input wire logic rd_b_in,
  input wire logic wr_b_in,
  input wire logic [3:0] ready_dly_in,
  // resolved lines back
  output logic [15:0] ad_wire_out,
  output logic ready_b_out
);
  logic [15:0] mem_r [0:255];
  logic [15:0] addr_r = 16'h0000;
  logic [15:0] last_r = 16'h0000;
  logic [15:0] drv;
  logic [3:0] cnt_r = 4'h0;
  // released lines show the inverse of the last value
  assign drv = rd_b_in ? ~last_r : mem_r[addr_r[7:0]];
  assign ad_wire_out = (ad_oe_in & ad_out_in) | (~ad_oe_in & drv);
  assign ready_b_out = (rd_b_in && wr_b_in) || (cnt_r < ready_dly_in);
  always @(posedge clk_in) begin
    if (ale_in) begin
      addr_r <= address_port_oe_in ? address_port_in : ad_out_in;
    end
    if (!wr_b_in) begin
      mem_r[addr_r[7:0]] <= ad_wire_out;
    end
    if (!rd_b_in) begin
      last_r <= drv;
    end
    cnt_r <= (rd_b_in && wr_b_in) ? 4'h0 : cnt_r + 4'h1;
  end
endmodule
`default_nettype wire

// >>> tb/tb_ext_bus_ctrl.sv
/*
  testbench of the external bus controller.
  assumes checker and memory model compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_ext_bus_ctrl;
  import ext_bus_pkg::*;
  // ==========================================
  // pins and state
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic req_in = 1'b0;
  logic req_wr_in = 1'b0;
  logic [23:0] req_addr_in = 24'h000000;
  logic [15:0] req_wdata_in = 16'h0000;
  bus_mode_t bus_mode_in = MODE_D16_MUX;
  addr_width_t addr_width_in = AW_24;
  can_assign_t can_assign_in = CAN_NONE;
  logic [63:0] window_select_reg_in = 64'h0;
  logic [7:0] default_bus_config_in = 8'h00;
  logic [31:0] window_bus_config_in = 32'h0;
  logic unlatched_select_bit_in = 1'b0;
  logic arbitration_enable_in = 1'b0;
  logic hold_ack_direction_bit_in = 1'b0;
  logic hold_b_in = 1'b1;
  logic ext_ack_b = 1'b0;
  logic [3:0] ready_dly = 4'h0;
  logic ack_out, address_port_oe_out, ale_out, rd_b_out, wr_b_out, ctrl_oe_out, ready_b_in;
  logic hold_ack_b_in, hold_ack_b_out, hold_ack_oe_out, bus_request_b_out;
  logic [15:0] rdata_out, address_port_out, addr_data_port_in, addr_data_port_out, addr_data_port_oe_out;
  logic [7:0] segment_out, segment_oe_out, seg_v, seg_a;
  logic [4:0] cs_b_out, cs_v;
  logic [15:0] rd_v;
  int fail_count = 0;
  int num_checks = 0;
  int lat;
  int l0;
  logic [7:0] cfgs [5] = '{8'h03, 8'h20, 8'h40, 8'h10, 8'h6f};
  int lats [5] = '{6, 4, 4, 3, 20};
  logic [23:0] wadr [3] = '{24'h001010, 24'h002010, 24'h005010};
  logic [4:0] wcs [3] = '{5'h1b, 5'h0f, 5'h1e};
  int wlat [3] = '{5, 4, 3};
  logic [7:0] segs [6] = '{8'h00, 8'h03, 8'h0f, 8'hff, 8'h3f, 8'h0f};
  assign hold_ack_b_in = hold_ack_oe_out ? hold_ack_b_out : ext_ack_b;
  ext_bus_ctrl dut (.*);
  ext_mem_model mem (.clk_in, .address_port_in(address_port_out), .address_port_oe_in(address_port_oe_out),
    .ad_out_in(addr_data_port_out), .ad_oe_in(addr_data_port_oe_out), .ale_in(ale_out), .rd_b_in(rd_b_out),
    .wr_b_in(wr_b_out), .ready_dly_in(ready_dly), .ad_wire_out(addr_data_port_in), .ready_b_out(ready_b_in));
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  // ==========================================
  // compare, access and closing tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_lat(input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      fail_count++;
      $display("MISMATCH t=%0t latency %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic go(input logic wr, input logic [23:0] a, input logic [15:0] d);
    @(posedge clk_in);
    req_in <= 1'b1;
    req_wr_in <= wr;
    req_addr_in <= a;
    req_wdata_in <= d;
  endtask
  task automatic done();
    lat = -1;
    for (int n = 0; n < 80; n++) begin
      @(posedge clk_in);
      #1;
      if (ale_out) begin
        cs_v = cs_b_out;
        seg_v = segment_oe_out;
        seg_a = segment_out;
      end
      if (ack_out === 1'b1) begin
        // take edge counted as the first
        lat = n + 1;
        rd_v = rdata_out;
        break;
      end
    end
    @(posedge clk_in);
    req_in <= 1'b0;
  endtask
  task automatic access(input logic wr, input logic [23:0] a, input logic [15:0] d);
    go(wr, a, d);
    done();
  endtask
  task automatic complete_run();
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #100us;
    fail_count++;
    complete_run();
  end
  // ==========================================
  // scenarios
  initial begin
    repeat (4) @(posedge clk_in);
    #1;
    chk(16'(cs_b_out), 16'h001f);
    chk(16'({hold_ack_oe_out, hold_ack_b_out}), 16'h0003);
    @(posedge clk_in);
    rst_b_in <= 1'b1;
    for (int m = 1; m < 5; m++) begin
      bus_mode_in <= bus_mode_t'(m);
      access(1'b1, 24'h00a000 + 24'(2 * m), 16'ha5c0 + 16'(m));
      access(1'b0, 24'h00a000 + 24'(2 * m), 16'h0000);
      chk(rd_v, m > 2 ? {8'h00, 8'hc0 + 8'(m)} : 16'ha5c0 + 16'(m));
      chk(16'(cs_v), 16'h001e);
      chk_lat(lat, 3);
    end
    foreach (cfgs[i]) begin
      default_bus_config_in <= cfgs[i];
      access(1'b0, 24'h00a004, 16'h0000);
      chk_lat(lat, lats[i]);
    end
    default_bus_config_in <= 8'h00;
    window_select_reg_in <= 64'h0020_0020_0010_0010;
    window_bus_config_in <= 32'h01000200;
    for (int u = 0; u < 2; u++) begin
      unlatched_select_bit_in <= u[0];
      foreach (wadr[i]) begin
        access(1'b0, wadr[i], 16'h0000);
        chk(16'(cs_v), 16'(wcs[i]));
        chk_lat(lat, wlat[i]);
      end
    end
    for (int w = 0; w < 6; w++) begin
      addr_width_in <= addr_width_t'(w > 3 ? 3 : w);
      can_assign_in <= can_assign_t'(w > 3 ? w - 3 : 0);
      access(1'b0, 24'hff5010, 16'h0000);
      chk(16'(seg_v), 16'(segs[w]));
      chk(16'(seg_a), 16'(w > 3 ? 8'hff : segs[w]));
    end
    can_assign_in <= CAN_NONE;
    default_bus_config_in <= 8'h80;
    access(1'b0, 24'h00a004, 16'h0000);
    l0 = lat;
    ready_dly <= 4'h4;
    access(1'b0, 24'h00a004, 16'h0000);
    chk(16'(lat > l0), 16'h0001);
    default_bus_config_in <= 8'h00;
    arbitration_enable_in <= 1'b1;
    hold_b_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    go(1'b0, 24'h00a004, 16'h0000);
    repeat (3) @(posedge clk_in);
    #1;
    chk(16'({hold_ack_b_out, ctrl_oe_out, bus_request_b_out, ack_out}), 16'h0000);
    @(posedge clk_in);
    hold_b_in <= 1'b1;
    done();
    chk(16'(lat > 2 && lat < 8), 16'h0001);
    hold_ack_direction_bit_in <= 1'b1;
    // pin still self-driven high one cycle after the switch
    repeat (2) @(posedge clk_in);
    access(1'b0, 24'h00a004, 16'h0000);
    chk_lat(lat, 3);
    chk(16'(hold_ack_oe_out), 16'h0000);
    ext_ack_b <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    chk(16'(ctrl_oe_out), 16'h0000);
    @(posedge clk_in);
    ext_ack_b <= 1'b0;
    bus_mode_in <= MODE_SINGLE;
    access(1'b0, 24'h00a004, 16'h0000);
    chk_lat(lat, -1);
    complete_run();
  end
endmodule
bind ext_bus_ctrl ext_bus_ctrl_asserts chk (.clk_in, .rst_b_in, .bus_mode_in, .addr_width_in, .can_assign_in,
  .arbitration_enable_in, .hold_ack_direction_bit_in, .ack_out, .address_port_oe_out, .addr_data_port_oe_out,
  .segment_oe_out, .ale_out, .rd_b_out, .wr_b_out, .ctrl_oe_out, .cs_b_out, .hold_ack_b_out, .hold_ack_oe_out);
`default_nettype wire
